// ---- dv/tqsl_assertions.sv ----
// port-level assertions for the reference-handling block
module tqsl_assertions import tqsl_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus handshakes
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // discrete inputs
  input wire logic direction_select_in_i,
  input wire logic speed_select_a_in_i,
  input wire logic speed_select_b_in_i,
  input wire logic alt_direction_select_in_i,
  input wire logic alt_speed_select_a_in_i,
  input wire logic alt_speed_select_b_in_i,
  // results
  input wire logic signed [15:0] torque_ref_o,
  input wire logic signed [15:0] speed_ref_o,
  input wire tqsl_speed_t speed_limit_o,
  input wire tqsl_method_t control_method_o,
  input wire logic speed_limit_active_out_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_wr_take;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_stop_sel;
    control_method_o == TQSL_M_PRESET && !speed_select_a_in_i &&
      !speed_select_b_in_i && !alt_speed_select_a_in_i &&
      !alt_speed_select_b_in_i;
  endsequence
  sequence s_rev_sel;
    control_method_o == TQSL_M_PRESET && direction_select_in_i &&
      alt_direction_select_in_i;
  endsequence
  property p_bvalid_lat;
    s_wr_take |-> ##[1:3] s_axi_bvalid_o;
  endproperty
  property p_bvalid_hold;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o;
  endproperty
  property p_rvalid_lat;
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
  endproperty
  property p_rvalid_hold;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && !s_axi_arready_o;
  endproperty
  property p_torque_off;
    (control_method_o != TQSL_M_TORQUE) [*2] |-> torque_ref_o == 16'sh0;
  endproperty
  property p_stop;
    s_stop_sel [*2] |-> speed_ref_o == 16'sh0;
  endproperty
  property p_reverse;
    s_rev_sel [*2] |-> speed_ref_o <= 16'sh0;
  endproperty
  property p_limit_range;
    speed_limit_o <= 16'h2710;
  endproperty
  property p_active_mode;
    (control_method_o != TQSL_M_TORQUE) [*3] |-> !speed_limit_active_out_o;
  endproperty
  a_bvalid_lat: assert property (p_bvalid_lat)
    else $error("write response late");
  a_bvalid_hold: assert property (p_bvalid_hold)
    else $error("write response dropped");
  a_rvalid_lat: assert property (p_rvalid_lat)
    else $error("read data late");
  a_rvalid_hold: assert property (p_rvalid_hold)
    else $error("read data dropped");
  a_torque_off: assert property (p_torque_off)
    else $error("torque output outside torque control");
  a_stop: assert property (p_stop)
    else $error("motor not stopped with selects off");
  a_reverse: assert property (p_reverse)
    else $error("reverse preset speed positive");
  a_limit_range: assert property (p_limit_range)
    else $error("speed limit above range");
  a_active_mode: assert property (p_active_mode)
    else $error("limit active outside torque control");
endmodule // tqsl_assertions

bind tqsl_top tqsl_assertions u_tqsl_assertions (.*);

// ---- dv/tqsl_host_model.sv ----
// host controller model driving the discrete speed and direction inputs
module tqsl_host_model (
  // clock and commands {direction, select a, select b}
  input wire logic clk_i,
  input wire logic alt_i,
  input wire logic split_i,
  input wire logic [2:0] cmd_i,
  // both allocations of the discrete inputs
  output logic [2:0] main_o = 3'h0,
  output logic [2:0] alt_o = 3'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  // with split_i set, the unused allocation shows the inverse so a wrong pick is seen
  always @(posedge clk_i) begin
    main_o <= (alt_i && split_i) ? ~cmd_i : cmd_i;
    alt_o <= (!alt_i && split_i) ? ~cmd_i : cmd_i;
  end
endmodule // tqsl_host_model

// ---- dv/tqsl_top_tb_top.sv ----
// self-checking bench for the reference-handling block
module tqsl_top_tb_top import tqsl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1;
  logic [7:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
  logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
  logic s_axi_arvalid_i = 0, s_axi_rready_i = 0;
  logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i = 4'hf;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic s_axi_rvalid_o, irq_o, speed_limit_active_out_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic signed [15:0] torque_ref_i = 0, speed_ref_analog_i = 0;
  logic signed [15:0] motor_speed_i = 0, torque_ref_o, speed_ref_o;
  tqsl_speed_t motor_max_speed_i = 16'h0bb8, overspeed_alarm_speed_i = 16'h0bb8;
  tqsl_speed_t rated_speed_i = 16'h0bb8, speed_limit_o;
  tqsl_method_t control_method_o;
  logic [2:0] cmd = 0, hm_main, hm_alt;
  logic alt = 0, split = 0;
  wire direction_select_in_i = hm_main[2];
  wire speed_select_a_in_i = hm_main[1];
  wire speed_select_b_in_i = hm_main[0];
  wire alt_direction_select_in_i = hm_alt[2];
  wire alt_speed_select_a_in_i = hm_alt[1];
  wire alt_speed_select_b_in_i = hm_alt[0];
  int bad_count = 0, n_compared = 0;
  logic [31:0] lfsr_st = 32'h0000_4882;
  logic [33:0] rq[$];
  logic [7:0] ra[8] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
  logic [31:0] rv[8] = '{32'h80, 32'h80, 0, 32'h2710, 32'h258, 32'h64,
    32'hc8, 32'h12c};

  tqsl_top DUT (.*);
  tqsl_host_model u_host (.clk_i(clk_i), .alt_i(alt), .split_i(split),
    .cmd_i(cmd), .main_o(hm_main), .alt_o(hm_alt));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  function automatic logic [31:0] lfsr();
    lfsr_st = {lfsr_st[30:0], 1'b0} ^ (lfsr_st[31] ? 32'h0400_0007 : 0);
    return lfsr_st;
  endfunction

  task automatic chk(string nm, logic [33:0] e, logic [33:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one idle edge first, so no handshake signal is set twice in a step
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er = 0);
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1;
    s_axi_wvalid_i <= 1;
    s_axi_bready_i <= 1;
    forever begin
      @(posedge clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 0;
      if (s_axi_bvalid_o) break;
    end
    s_axi_bready_i <= 0;
    chk("bresp", er, s_axi_bresp_o);
  endtask

  task automatic rd(logic [7:0] a, logic [33:0] e);
    @(posedge clk_i);
    rq.push_back(e);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1;
    s_axi_rready_i <= 1;
    do @(posedge clk_i); while (!s_axi_arready_o);
    s_axi_arvalid_i <= 0;
    do @(posedge clk_i); while (!s_axi_rvalid_o);
    s_axi_rready_i <= 0;
  endtask

  task automatic restart(logic [31:0] c);
    wr(8'h04, c);
    wr(8'h00, 32'h1);
    repeat (4) @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    if (s_axi_rvalid_o && s_axi_rready_i) begin
      chk("rdata", rq.pop_front(), {s_axi_rresp_o, s_axi_rdata_o});
    end
  end

  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #100000;
    bad_count++;
    stop_test();
  end

  initial begin
    int p[3];
    int sp;
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    foreach (ra[i])
      rd(ra[i], {2'b00, rv[i]});
    rd(8'h30, {2'b10, 32'h0});
    wr(8'h30, 32'h1, 2'b10);
    wr(8'h14, 32'h000a);
    rd(8'h14, {2'b00, 32'h96});
    wr(8'h14, 32'h1388);
    rd(8'h14, {2'b00, 32'hbb8});
    wr(8'h14, 32'h258);
    for (int i = 0; i < 3; i++) begin
      p[i] = int'(lfsr() % 6000);
      wr(8'(8'h18 + 4 * i), 32'(p[i]));
    end
    for (int k = 0; k < 2; k++) begin
      restart(32'h83 | (k << 6));
      chk("method", TQSL_M_PRESET, control_method_o);
      alt <= k[0];
      split <= k[0];
      for (int c = 0; c < 8; c++) begin
        cmd <= 3'(c);
        repeat (4) @(posedge clk_i);
        sp = c[1] ? (c[0] ? p[1] : p[2]) : (c[0] ? p[0] : 0);
        if (sp > 3000) sp = 3000;
        chk("speed", 16'(c[2] ? -sp : sp), speed_ref_o);
      end
    end
    // a method change written without restart must stay pending
    wr(8'h04, 32'h82);
    chk("pending", TQSL_M_PRESET, control_method_o);
    split <= 0;
    wr(8'h2c, 32'h1);
    wr(8'h10, 32'h1f4);
    restart(32'h82);
    torque_ref_i <= 16'(lfsr());
    repeat (3) @(posedge clk_i);
    chk("torque", torque_ref_i, torque_ref_o);
    motor_speed_i <= 16'sd600;
    repeat (4) @(posedge clk_i);
    chk("limit", 500, speed_limit_o);
    chk("active", 1, speed_limit_active_out_o);
    chk("irq", 1, irq_o);
    motor_speed_i <= 0;
    repeat (4) @(posedge clk_i);
    chk("inactive", 0, speed_limit_active_out_o);
    wr(8'h28, 32'h1);
    chk("irq clear", 0, irq_o);
    wr(8'h10, 32'h2328);
    repeat (4) @(posedge clk_i);
    chk("ceil max", 3000, speed_limit_o);
    overspeed_alarm_speed_i <= 16'h0dac;
    restart(32'ha2);
    chk("ceil ovs", 3500, speed_limit_o);
    restart(32'h92);
    speed_ref_analog_i <= -16'sd3000;
    repeat (4) @(posedge clk_i);
    chk("ext", 1500, speed_limit_o);
    wr(8'h10, 32'h3e8);
    repeat (4) @(posedge clk_i);
    chk("ext min", 1000, speed_limit_o);
    wr(8'h2c, 32'h0);
    restart(32'h12);
    motor_speed_i <= -16'sd2000;
    repeat (4) @(posedge clk_i);
    chk("pin off", 0, speed_limit_active_out_o);
    chk("masked", 0, irq_o);
    stop_test();
  end
endmodule // tqsl_top_tb_top

// ---- rtl/tqsl_lag_filter.sv ----
// first-order lag filter on the torque reference
`include "tqsl_regs.svh"
module tqsl_lag_filter (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control cycle enable
  input wire logic tick_i,
  // time constant in control cycles, and samples
  input wire logic [15:0] time_const_i,
  input wire logic signed [15:0] ref_i,
  output logic signed [15:0] ref_o
);
  import tqsl_pkg::*;

  // state in 16.16 fixed point so small steps are not lost
  logic signed [31:0] acc_reg;
  logic signed [31:0] acc_next;
  logic [16:0] coef;
  logic signed [32:0] diff;
  logic signed [50:0] step;

  // discretised gain 1/(tc+1); a divider trades area for exactness
  function automatic logic [16:0] lag_coef(input logic [15:0] tc);
    logic [16:0] den;
    den = {1'b0, tc} + 17'h0_0001;
    lag_coef = 17'h1_0000 / den;
  endfunction

  always_comb begin
    coef = lag_coef(time_const_i);
    diff = 33'($signed({ref_i, 16'h0000})) - 33'(acc_reg);
    step = 51'(diff * $signed({1'b0, coef})) >>> 16;
    acc_next = acc_reg;
    if (time_const_i == 16'h0000) begin
      acc_next = {ref_i, 16'h0000};
    end else if (tick_i) begin
      acc_next = acc_reg + step[31:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_reg <= 32'h0000_0000;
    end else begin
      acc_reg <= acc_next;
    end
  end

  assign ref_o = acc_reg[31:16];
endmodule // tqsl_lag_filter

// ---- rtl/tqsl_pkg.sv ----
// types shared by the reference-handling block
package tqsl_pkg;
  typedef enum logic [3:0] {
    TQSL_M_SPEED = 4'h0,
    TQSL_M_POSITION = 4'h1,
    TQSL_M_TORQUE = 4'h2,
    TQSL_M_PRESET = 4'h3
  } tqsl_method_t;

  typedef enum logic [1:0] {
    TQSL_WR_COLLECT = 2'b01,
    TQSL_WR_RESP = 2'b10
  } tqsl_wr_state_t;

  typedef logic [15:0] tqsl_speed_t;
endpackage : tqsl_pkg

// ---- rtl/tqsl_regs.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef TQSL_REGS_SVH
`define TQSL_REGS_SVH

`define TQSL_CLK_PERIOD_NS 4
`define TQSL_CTRL_PERIOD_NS 10000
`define TQSL_CTRL_CYCLES (`TQSL_CTRL_PERIOD_NS / `TQSL_CLK_PERIOD_NS)

`define TQSL_ADDR_CTRL 8'h00
`define TQSL_ADDR_CFG 8'h04
`define TQSL_ADDR_CFG_ACT 8'h08
`define TQSL_ADDR_TFILT 8'h0C
`define TQSL_ADDR_INTLIM 8'h10
`define TQSL_ADDR_GAIN 8'h14
`define TQSL_ADDR_PRESET1 8'h18
`define TQSL_ADDR_PRESET2 8'h1C
`define TQSL_ADDR_PRESET3 8'h20
`define TQSL_ADDR_STATUS 8'h24
`define TQSL_ADDR_IRQ_STAT 8'h28
`define TQSL_ADDR_IRQ_MASK 8'h2C

`define TQSL_CTRL_RESTART_BIT 0
`define TQSL_CFG_METHOD_LSB 0
`define TQSL_CFG_LIMSRC_BIT 4
`define TQSL_CFG_CEIL_BIT 5
`define TQSL_CFG_ALLOC_BIT 6
`define TQSL_CFG_PIN_BIT 7
`define TQSL_IRQ_LIMIT_BIT 0
`define TQSL_IRQ_PRESET_BIT 1

`define TQSL_CFG_RESET 8'h80
`define TQSL_TFILT_RESET 16'h0000
`define TQSL_INTLIM_RESET 16'h2710
`define TQSL_SPEED_MAX 16'h2710
`define TQSL_GAIN_RESET 16'h0258
`define TQSL_GAIN_MIN 16'h0096
`define TQSL_GAIN_MAX 16'h0BB8
`define TQSL_PRESET1_RESET 16'h0064
`define TQSL_PRESET2_RESET 16'h00C8
`define TQSL_PRESET3_RESET 16'h012C
`define TQSL_MV_PER_GAIN_UNIT 16'h000A

`endif

// ---- rtl/tqsl_speed_limit.sv ----
// speed limit value and limit-active detection for torque control
`include "tqsl_regs.svh"
module tqsl_speed_limit (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // settings
  input wire logic ext_src_i,
  input wire logic ceil_overspeed_i,
  input wire logic torque_mode_i,
  input wire tqsl_pkg::tqsl_speed_t int_limit_i,
  input wire logic [15:0] gain_i,
  // motor data and measurements
  input wire tqsl_pkg::tqsl_speed_t motor_max_i,
  input wire tqsl_pkg::tqsl_speed_t overspeed_i,
  input wire tqsl_pkg::tqsl_speed_t rated_i,
  input wire logic signed [15:0] analog_mv_i,
  input wire logic signed [15:0] motor_speed_i,
  // results
  output tqsl_pkg::tqsl_speed_t limit_o,
  output logic active_o
);
  import tqsl_pkg::*;

  tqsl_speed_t limit_reg;
  tqsl_speed_t limit_next;
  logic active_reg;
  logic active_next;
  logic [15:0] mag_v;
  logic [15:0] mag_spd;
  logic [31:0] ext_lim;
  logic [31:0] den;
  tqsl_speed_t ceil_spd;
  tqsl_speed_t lim;

  function automatic logic [15:0] abs16(input logic signed [15:0] v);
    abs16 = v[15] ? 16'(-v) : 16'(v);
  endfunction

  always_comb begin
    mag_v = abs16(analog_mv_i);
    mag_spd = abs16(motor_speed_i);
    den = 32'(gain_i) * 32'(`TQSL_MV_PER_GAIN_UNIT);
    ext_lim = (32'(mag_v) * 32'(rated_i)) / den;
    ceil_spd = ceil_overspeed_i ? overspeed_i : motor_max_i;
    lim = int_limit_i;
    if (ext_src_i && ext_lim < 32'(lim)) begin
      lim = ext_lim[15:0];
    end
    if (lim > ceil_spd) begin
      lim = ceil_spd;
    end
    limit_next = lim;
    // holding the reference at the limit is done by the speed loop
    active_next = torque_mode_i && (mag_spd >= lim);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      limit_reg <= `TQSL_INTLIM_RESET;
      active_reg <= 1'b0;
    end else begin
      limit_reg <= limit_next;
      active_reg <= active_next;
    end
  end

  assign limit_o = limit_reg;
  assign active_o = active_reg;
endmodule // tqsl_speed_limit

// ---- rtl/tqsl_top.sv ----
// torque filter, torque-mode speed limit and preset speed control
//
// The address map and the AXI4-Lite register port were left to the implementer.
`include "tqsl_regs.svh"
module tqsl_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // axi4-lite write address, data and response
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // host discrete and analog inputs
  input wire logic signed [15:0] torque_ref_i,
  input wire logic signed [15:0] speed_ref_analog_i,
  input wire logic direction_select_in_i,
  input wire logic speed_select_a_in_i,
  input wire logic speed_select_b_in_i,
  input wire logic alt_direction_select_in_i,
  input wire logic alt_speed_select_a_in_i,
  input wire logic alt_speed_select_b_in_i,
  // motor data and feedback
  input wire tqsl_pkg::tqsl_speed_t motor_max_speed_i,
  input wire tqsl_pkg::tqsl_speed_t overspeed_alarm_speed_i,
  input wire tqsl_pkg::tqsl_speed_t rated_speed_i,
  input wire logic signed [15:0] motor_speed_i,
  // references and status to the drive
  output logic signed [15:0] torque_ref_o,
  output logic signed [15:0] speed_ref_o,
  output tqsl_pkg::tqsl_speed_t speed_limit_o,
  output tqsl_pkg::tqsl_method_t control_method_o,
  output logic speed_limit_active_out_o,
  output logic irq_o
);
  import tqsl_pkg::*;

  // control cycle divider
  logic [11:0] div_reg;
  logic [11:0] div_next;
  logic tick;

  always_comb begin
    tick = (div_reg == 12'(`TQSL_CTRL_CYCLES - 1));
    div_next = tick ? 12'h000 : div_reg + 12'h001;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= 12'h000;
    end else begin
      div_reg <= div_next;
    end
  end

  // axi write channel: address and data taken in either order
  tqsl_wr_state_t wr_state_reg;
  tqsl_wr_state_t wr_state_next;
  logic aw_have_reg;
  logic aw_have_next;
  logic w_have_reg;
  logic w_have_next;
  logic [7:0] aw_addr_reg;
  logic [7:0] aw_addr_next;
  logic [31:0] w_data_reg;
  logic [31:0] w_data_next;
  logic [3:0] w_strb_reg;
  logic [3:0] w_strb_next;
  logic wr_fire;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a[1:0] == 2'b00) && (a <= `TQSL_ADDR_IRQ_MASK);
  endfunction

  always_comb begin
    wr_state_next = wr_state_reg;
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    aw_addr_next = aw_addr_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bresp_next = bresp_reg;
    wr_fire = 1'b0;
    unique case (wr_state_reg)
      TQSL_WR_COLLECT: begin
        if (s_axi_awvalid_i && !aw_have_reg) begin
          aw_have_next = 1'b1;
          aw_addr_next = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !w_have_reg) begin
          w_have_next = 1'b1;
          w_data_next = s_axi_wdata_i;
          w_strb_next = s_axi_wstrb_i;
        end
        if (aw_have_reg && w_have_reg) begin
          wr_fire = 1'b1;
          bresp_next = addr_known(aw_addr_reg) ? 2'b00 : 2'b10;
          aw_have_next = 1'b0;
          w_have_next = 1'b0;
          wr_state_next = TQSL_WR_RESP;
        end
      end
      TQSL_WR_RESP: begin
        if (s_axi_bready_i) begin
          wr_state_next = TQSL_WR_COLLECT;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_state_reg <= TQSL_WR_COLLECT;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bresp_reg <= 2'b00;
    end else begin
      wr_state_reg <= wr_state_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      aw_addr_reg <= aw_addr_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bresp_reg <= bresp_next;
    end
  end

  assign s_axi_awready_o = (wr_state_reg == TQSL_WR_COLLECT) && !aw_have_reg;
  assign s_axi_wready_o = (wr_state_reg == TQSL_WR_COLLECT) && !w_have_reg;
  assign s_axi_bvalid_o = (wr_state_reg == TQSL_WR_RESP);
  assign s_axi_bresp_o = bresp_reg;

  // settings; "after restart" fields are pending until a restart
  logic [7:0] cfg_reg, cfg_next, act_reg, act_next;
  logic [15:0] tfilt_reg, tfilt_next, intlim_reg, intlim_next;
  logic [15:0] gain_reg, gain_next;
  logic [15:0] preset_reg [3];
  logic [15:0] preset_next [3];
  logic [1:0] irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next;
  logic [1:0] irq_event;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic restart;

  function automatic logic [15:0] clamp(input logic [15:0] v,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  always_comb begin
    wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
             {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    wval = w_data_reg & wmask;
    cfg_next = cfg_reg;
    tfilt_next = tfilt_reg;
    intlim_next = intlim_reg;
    gain_next = gain_reg;
    preset_next = preset_reg;
    irq_mask_next = irq_mask_reg;
    restart = 1'b0;
    irq_stat_next = irq_stat_reg;
    if (wr_fire) begin
      unique case (aw_addr_reg)
        `TQSL_ADDR_CTRL: restart = wval[`TQSL_CTRL_RESTART_BIT];
        `TQSL_ADDR_CFG: cfg_next = wval[7:0];
        `TQSL_ADDR_TFILT: tfilt_next = wval[15:0];
        `TQSL_ADDR_INTLIM:
          intlim_next = clamp(wval[15:0], 16'h0000,
                              `TQSL_SPEED_MAX);
        `TQSL_ADDR_GAIN:
          gain_next = clamp(wval[15:0], `TQSL_GAIN_MIN,
                            `TQSL_GAIN_MAX);
        `TQSL_ADDR_PRESET1:
          preset_next[0] = clamp(wval[15:0], 16'h0000,
                                 `TQSL_SPEED_MAX);
        `TQSL_ADDR_PRESET2:
          preset_next[1] = clamp(wval[15:0], 16'h0000,
                                 `TQSL_SPEED_MAX);
        `TQSL_ADDR_PRESET3:
          preset_next[2] = clamp(wval[15:0], 16'h0000,
                                 `TQSL_SPEED_MAX);
        `TQSL_ADDR_IRQ_STAT: irq_stat_next = irq_stat_reg & ~wval[1:0];
        `TQSL_ADDR_IRQ_MASK: irq_mask_next = wval[1:0];
        default: ;
      endcase
    end
    // a new event wins over a simultaneous clear
    irq_stat_next = irq_stat_next | irq_event;
    act_next = restart ? cfg_reg : act_reg;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg <= `TQSL_CFG_RESET;
      act_reg <= `TQSL_CFG_RESET;
      tfilt_reg <= `TQSL_TFILT_RESET;
      intlim_reg <= `TQSL_INTLIM_RESET;
      gain_reg <= `TQSL_GAIN_RESET;
      preset_reg[0] <= `TQSL_PRESET1_RESET;
      preset_reg[1] <= `TQSL_PRESET2_RESET;
      preset_reg[2] <= `TQSL_PRESET3_RESET;
      irq_stat_reg <= 2'b00;
      irq_mask_reg <= 2'b00;
    end else begin
      cfg_reg <= cfg_next;
      act_reg <= act_next;
      tfilt_reg <= tfilt_next;
      intlim_reg <= intlim_next;
      gain_reg <= gain_next;
      preset_reg <= preset_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  tqsl_method_t method;
  logic torque_mode;
  logic preset_mode;
  logic alloc_alt;

  assign method = tqsl_method_t'(act_reg[`TQSL_CFG_METHOD_LSB +: 4]);
  assign torque_mode = (method == TQSL_M_TORQUE);
  assign preset_mode = (method == TQSL_M_PRESET);
  assign alloc_alt = act_reg[`TQSL_CFG_ALLOC_BIT];

  // torque reference path
  logic signed [15:0] tref_filt;

  tqsl_lag_filter u_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .time_const_i(tfilt_reg),
    .ref_i(torque_ref_i),
    .ref_o(tref_filt)
  );

  // speed limit
  tqsl_speed_t lim_val;
  logic lim_active;

  tqsl_speed_limit u_limit (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ext_src_i(act_reg[`TQSL_CFG_LIMSRC_BIT]),
    .ceil_overspeed_i(act_reg[`TQSL_CFG_CEIL_BIT]),
    .torque_mode_i(torque_mode),
    .int_limit_i(intlim_reg),
    .gain_i(gain_reg),
    .motor_max_i(motor_max_speed_i),
    .overspeed_i(overspeed_alarm_speed_i),
    .rated_i(rated_speed_i),
    .analog_mv_i(speed_ref_analog_i),
    .motor_speed_i(motor_speed_i),
    .limit_o(lim_val),
    .active_o(lim_active)
  );

  // preset speed selection and output registers
  logic dir_rev, sel_a, sel_b;
  logic [1:0] pidx, pidx_reg;
  logic [15:0] pspd;
  logic signed [15:0] sref_next, sref_reg, tref_next, tref_reg;
  logic vlt_next, vlt_reg, lim_prev_reg;

  always_comb begin
    dir_rev = alloc_alt ? alt_direction_select_in_i : direction_select_in_i;
    sel_a = alloc_alt ? alt_speed_select_a_in_i : speed_select_a_in_i;
    sel_b = alloc_alt ? alt_speed_select_b_in_i : speed_select_b_in_i;
    unique case ({sel_a, sel_b})
      2'b01: pidx = 2'd1;
      2'b11: pidx = 2'd2;
      2'b10: pidx = 2'd3;
      default: pidx = 2'd0;
    endcase
    pspd = (pidx == 2'd0) ? 16'h0000 : preset_reg[pidx - 2'd1];
    if (pspd > motor_max_speed_i) begin
      pspd = motor_max_speed_i;
    end
    sref_next = 16'sh0000;
    if (preset_mode) begin
      sref_next = dir_rev ? -$signed(pspd) : $signed(pspd);
    end
    tref_next = torque_mode ? tref_filt : 16'sh0000;
    vlt_next = lim_active && act_reg[`TQSL_CFG_PIN_BIT];
    irq_event[`TQSL_IRQ_LIMIT_BIT] = lim_active && !lim_prev_reg;
    irq_event[`TQSL_IRQ_PRESET_BIT] = preset_mode && (pidx != pidx_reg);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sref_reg <= 16'sh0000;
      tref_reg <= 16'sh0000;
      vlt_reg <= 1'b0;
      lim_prev_reg <= 1'b0;
      pidx_reg <= 2'd0;
    end else begin
      sref_reg <= sref_next;
      tref_reg <= tref_next;
      vlt_reg <= vlt_next;
      lim_prev_reg <= lim_active;
      pidx_reg <= pidx;
    end
  end

  // axi read channel, one outstanding read
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rd_mux;

  always_comb begin
    unique case (s_axi_araddr_i)
      `TQSL_ADDR_CFG: rd_mux = {24'h00_0000, cfg_reg};
      `TQSL_ADDR_CFG_ACT: rd_mux = {24'h00_0000, act_reg};
      `TQSL_ADDR_TFILT: rd_mux = {16'h0000, tfilt_reg};
      `TQSL_ADDR_INTLIM: rd_mux = {16'h0000, intlim_reg};
      `TQSL_ADDR_GAIN: rd_mux = {16'h0000, gain_reg};
      `TQSL_ADDR_PRESET1: rd_mux = {16'h0000, preset_reg[0]};
      `TQSL_ADDR_PRESET2: rd_mux = {16'h0000, preset_reg[1]};
      `TQSL_ADDR_PRESET3: rd_mux = {16'h0000, preset_reg[2]};
      `TQSL_ADDR_STATUS:
        rd_mux = {lim_val, 12'h000, pidx_reg, vlt_reg, lim_active};
      `TQSL_ADDR_IRQ_STAT: rd_mux = {30'h0000_0000, irq_stat_reg};
      `TQSL_ADDR_IRQ_MASK: rd_mux = {30'h0000_0000, irq_mask_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (rvalid_reg && s_axi_rready_i) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid_i && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rdata_next = rd_mux;
      rresp_next = addr_known(s_axi_araddr_i) ? 2'b00 : 2'b10;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'b00;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign s_axi_arready_o = !rvalid_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;

  assign torque_ref_o = tref_reg;
  assign speed_ref_o = sref_reg;
  assign speed_limit_o = lim_val;
  assign control_method_o = method;
  assign speed_limit_active_out_o = vlt_reg;
  assign irq_o = |(irq_stat_reg & irq_mask_reg);
endmodule // tqsl_top
